// >>> logic/input_filter.sv
`default_nettype none
module input_filter
    import motor_bridge_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] raw_i,
    output logic [WIDTH-1:0] filtered_o
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;

    initial begin
        if (WIDTH < 1) begin
            $error("input_filter needs WIDTH of at least 1");
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            stage1_q <= RESET_VALUE;
            stage2_q <= RESET_VALUE;
            stage3_q <= RESET_VALUE;
        end else begin
            stage1_q <= raw_i;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // a bit moves only once the last two stages agree, which rejects one-sample glitches
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            filtered_o <= RESET_VALUE;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_q[i] == stage3_q[i]) begin
                    filtered_o[i] <= stage3_q[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> logic/motor_bridge_pkg.sv
`default_nettype none
package motor_bridge_pkg;
    localparam int FRAME_BITS = 16;
    localparam int SWITCH_COUNT = 12;
    localparam int HALF_BRIDGE_COUNT = 6;
    localparam int SYNC_STAGES = 3;
    localparam int BIT_COUNT_WIDTH = 5;
    localparam logic [4:0] FRAME_BIT_COUNT = 5'h10;
    localparam logic [4:0] BIT_COUNT_LIMIT = 5'h11;

    // command word field positions
    localparam int CMD_STATUS_CLEAR_ARM_BIT = 0;
    localparam int CMD_FIRST_SWITCH_BIT = 1;
    localparam int CMD_LAST_SWITCH_BIT = 12;
    localparam int CMD_OVERCURRENT_CLEAR_BIT = 13;
    localparam int CMD_OVERTEMP_CLEAR_BIT = 14;
    localparam int CMD_OVERVOLTAGE_CLEAR_BIT = 15;

    // status word field positions
    localparam int STS_UNUSED_BIT = 0;
    localparam int STS_FIRST_SWITCH_BIT = 1;
    localparam int STS_LAST_SWITCH_BIT = 12;
    localparam int STS_OVERCURRENT_BIT = 13;
    localparam int STS_OVERTEMP_BIT = 14;
    localparam int STS_OVERVOLTAGE_BIT = 15;

    localparam logic [11:0] SWITCH_CTRL_RESET = 12'h000;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    typedef enum logic [0:0] {
        LINK_IDLE = 1'b0,
        LINK_ACTIVE = 1'b1
    } link_state_type;
endpackage
`default_nettype wire

// >>> logic/motor_bridge_serial_command_status.sv
`default_nettype none
module motor_bridge_serial_command_status
    import motor_bridge_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    output logic serial_data_o,
    input wire logic overcurrent_detect_i,
    input wire logic overtemp_detect_i,
    input wire logic supply_overvoltage_detect_i,
    output logic [11:0] switch_on_o,
    output logic [5:0] half_bridge_hiz_o,
    output logic overcurrent_flag_o,
    output logic overtemp_flag_o,
    output logic supply_overvoltage_flag_o
);
    logic [2:0] link_filtered;
    logic [2:0] detect_filtered;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic oc_level;
    logic ot_level;
    logic ov_level;
    logic ot_prev_q;
    logic ov_prev_q;
    logic ot_fall;
    logic ov_fall;
    logic frame_done;
    logic [15:0] command_word;
    logic [15:0] status_word;
    logic [11:0] switch_ctrl_q;
    logic overcurrent_flag_q;
    logic overtemp_flag_q;
    logic supply_overvoltage_flag_q;
    logic oc_lockout_q;
    logic ot_lockout_q;
    logic ov_lockout_q;
    logic forced_off;
    logic combined_clear;
    logic clear_oc;
    logic clear_ot;
    logic clear_ov;
    logic [11:0] switch_on_d;

    // half-bridge gating: shoot-through and any fault lockout both end in high impedance
    function automatic logic [1:0] gate_half_bridge(input logic high_req, input logic low_req,
                                                    input logic forced);
        logic [1:0] result;
        result = 2'b00;
        if (!forced && !(high_req && low_req)) begin
            result = {low_req, high_req};
        end
        return result;
    endfunction

    input_filter #(
        .WIDTH(3),
        .RESET_VALUE(3'h4)
    ) link_filter (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .raw_i({chip_select_n_i, serial_clock_i, serial_data_i}),
        .filtered_o(link_filtered)
    );

    input_filter #(
        .WIDTH(3),
        .RESET_VALUE(3'h0)
    ) detect_filter (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .raw_i({overcurrent_detect_i, overtemp_detect_i, supply_overvoltage_detect_i}),
        .filtered_o(detect_filtered)
    );

    assign cs_n = link_filtered[2];
    assign sclk = link_filtered[1];
    assign sdi = link_filtered[0];
    assign oc_level = detect_filtered[2];
    assign ot_level = detect_filtered[1];
    assign ov_level = detect_filtered[0];

    serial_frame_shifter shifter (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .chip_select_n_i(cs_n),
        .serial_clock_i(sclk),
        .serial_data_i(sdi),
        .status_word_i(status_word),
        .serial_data_o(serial_data_o),
        .frame_done_o(frame_done),
        .command_word_o(command_word)
    );

    // bit 0 only arms the clear; on its own it has no effect
    assign combined_clear = frame_done & command_word[CMD_STATUS_CLEAR_ARM_BIT]
                            & command_word[CMD_OVERVOLTAGE_CLEAR_BIT];
    assign clear_oc = combined_clear
                      | (frame_done & command_word[CMD_OVERCURRENT_CLEAR_BIT]);
    assign clear_ot = combined_clear
                      | (frame_done & command_word[CMD_OVERTEMP_CLEAR_BIT]);
    assign clear_ov = frame_done & command_word[CMD_OVERVOLTAGE_CLEAR_BIT];

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ot_prev_q <= 1'b0;
            ov_prev_q <= 1'b0;
        end else begin
            ot_prev_q <= ot_level;
            ov_prev_q <= ov_level;
        end
    end

    assign ot_fall = ot_prev_q & ~ot_level;
    assign ov_fall = ov_prev_q & ~ov_level;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            switch_ctrl_q <= SWITCH_CTRL_RESET;
        end else if (combined_clear) begin
            switch_ctrl_q <= SWITCH_CTRL_RESET;
        end else if (frame_done) begin
            switch_ctrl_q <= command_word[CMD_LAST_SWITCH_BIT:CMD_FIRST_SWITCH_BIT];
        end
    end

    // sticky flags: a detection in the clearing cycle wins over the clear
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            overcurrent_flag_q <= 1'b0;
            overtemp_flag_q <= 1'b0;
            supply_overvoltage_flag_q <= 1'b0;
        end else begin
            overcurrent_flag_q <= oc_level | (overcurrent_flag_q & ~clear_oc);
            overtemp_flag_q <= ot_level | (overtemp_flag_q & ~clear_ot);
            supply_overvoltage_flag_q <= ov_level
                                         | (supply_overvoltage_flag_q & ~clear_ov);
        end
    end

    // lockouts keep outputs off; thermal and supply ones also lift when the detector recovers
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            oc_lockout_q <= 1'b0;
            ot_lockout_q <= 1'b0;
            ov_lockout_q <= 1'b0;
        end else begin
            oc_lockout_q <= oc_level | (oc_lockout_q & ~clear_oc);
            ot_lockout_q <= ot_level | (ot_lockout_q & ~(clear_ot | ot_fall));
            ov_lockout_q <= ov_level | (ov_lockout_q & ~(clear_ov | ov_fall));
        end
    end

    assign forced_off = oc_lockout_q | ot_lockout_q | ov_lockout_q;

    // pairs are {high, low} in ascending command bit order, first pair is channel A1
    for (genvar h = 0; h < HALF_BRIDGE_COUNT; h++) begin : g_half_bridge
        assign switch_on_d[2*h+1:2*h] = gate_half_bridge(switch_ctrl_q[2*h],
                                                         switch_ctrl_q[2*h+1],
                                                         forced_off);
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            switch_on_o <= SWITCH_CTRL_RESET;
            half_bridge_hiz_o <= 6'h3f;
        end else begin
            switch_on_o <= switch_on_d;
            for (int h = 0; h < HALF_BRIDGE_COUNT; h++) begin
                half_bridge_hiz_o[h] <= ~(switch_on_d[2*h] | switch_on_d[2*h+1]);
            end
        end
    end

    assign overcurrent_flag_o = overcurrent_flag_q;
    assign overtemp_flag_o = overtemp_flag_q;
    assign supply_overvoltage_flag_o = supply_overvoltage_flag_q;

    always_comb begin
        status_word = WORD_RESET;
        status_word[STS_UNUSED_BIT] = 1'b0;
        status_word[STS_LAST_SWITCH_BIT:STS_FIRST_SWITCH_BIT] = switch_on_o;
        status_word[STS_OVERCURRENT_BIT] = overcurrent_flag_q;
        status_word[STS_OVERTEMP_BIT] = overtemp_flag_q;
        status_word[STS_OVERVOLTAGE_BIT] = supply_overvoltage_flag_q;
    end
endmodule
`default_nettype wire

// >>> logic/serial_frame_shifter.sv
`default_nettype none
module serial_frame_shifter
    import motor_bridge_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    input wire logic [15:0] status_word_i,
    output logic serial_data_o,
    output logic frame_done_o,
    output logic [15:0] command_word_o
);
    link_state_type link_state_q;
    logic cs_prev_q;
    logic sclk_prev_q;
    logic [15:0] tx_q;
    logic [15:0] rx_q;
    logic [4:0] bit_count_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    assign cs_fall = cs_prev_q & ~chip_select_n_i;
    assign cs_rise = ~cs_prev_q & chip_select_n_i;
    assign sclk_rise = ~sclk_prev_q & serial_clock_i;
    assign sclk_fall = sclk_prev_q & ~serial_clock_i;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            cs_prev_q <= chip_select_n_i;
            sclk_prev_q <= serial_clock_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            link_state_q <= LINK_IDLE;
        end else begin
            case (link_state_q)
                LINK_IDLE: begin
                    if (cs_fall) begin
                        link_state_q <= LINK_ACTIVE;
                    end
                end
                LINK_ACTIVE: begin
                    if (cs_rise) begin
                        link_state_q <= LINK_IDLE;
                    end
                end
                default: begin
                    link_state_q <= LINK_IDLE;
                end
            endcase
        end
    end

    // status is snapshotted when the frame opens so the word shifted out is coherent
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            tx_q <= WORD_RESET;
            serial_data_o <= 1'b0;
        end else if (cs_fall) begin
            tx_q <= status_word_i;
            serial_data_o <= 1'b0;
        end else if (link_state_q == LINK_ACTIVE && sclk_rise) begin
            serial_data_o <= tx_q[FRAME_BITS-1];
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
        end else if (link_state_q == LINK_IDLE) begin
            serial_data_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rx_q <= WORD_RESET;
            bit_count_q <= '0;
        end else if (cs_fall) begin
            bit_count_q <= '0;
        end else if (link_state_q == LINK_ACTIVE && sclk_fall) begin
            rx_q <= {rx_q[FRAME_BITS-2:0], serial_data_i};
            if (bit_count_q != BIT_COUNT_LIMIT) begin
                bit_count_q <= bit_count_q + 5'h01;
            end
        end
    end

    // a frame of any other length is dropped rather than applied half-shifted
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            frame_done_o <= 1'b0;
            command_word_o <= WORD_RESET;
        end else begin
            frame_done_o <= 1'b0;
            if (link_state_q == LINK_ACTIVE && cs_rise && bit_count_q == FRAME_BIT_COUNT) begin
                frame_done_o <= 1'b1;
                command_word_o <= rx_q;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/motor_bridge_chk.sv
`default_nettype none
module motor_bridge_chk (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    input wire logic serial_data_o,
    input wire logic overcurrent_detect_i,
    input wire logic overtemp_detect_i,
    input wire logic supply_overvoltage_detect_i,
    input wire logic [11:0] switch_on_o,
    input wire logic [5:0] half_bridge_hiz_o,
    input wire logic overcurrent_flag_o,
    input wire logic overtemp_flag_o,
    input wire logic supply_overvoltage_flag_o
);
    logic [4:0] since_cs_q;
    logic [4:0] since_rise_q;
    logic sclk_prev_q;
    logic [5:0] hiz_exp;
    always_ff @(posedge clock_i) begin
        if (srst_i || !chip_select_n_i) since_cs_q <= 5'h00;
        else if (since_cs_q != 5'h1f) since_cs_q <= since_cs_q + 5'h01;
    end
    always_ff @(posedge clock_i) begin
        sclk_prev_q <= serial_clock_i;
        if (serial_clock_i && !sclk_prev_q) since_rise_q <= 5'h00;
        else if (since_rise_q != 5'h1f) since_rise_q <= since_rise_q + 5'h01;
    end
    always_comb begin
        for (int h = 0; h < 6; h++) hiz_exp[h] = !(switch_on_o[2*h] | switch_on_o[2*h+1]);
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    property p_hiz_map; half_bridge_hiz_o == hiz_exp; endproperty
    a_hiz_map: assert property (p_hiz_map) else $error("hiz disagrees with switches");
    property p_no_shoot; (switch_on_o & (switch_on_o >> 1) & 12'h555) == 12'h000; endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both sides on");
    property p_oc_off;
        $rose(overcurrent_detect_i) |-> ##[1:10] (switch_on_o == 12'h000 && overcurrent_flag_o);
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("overcurrent not handled");
    property p_ot_off; $rose(overtemp_detect_i) |-> ##[1:10] (switch_on_o == 12'h000 && overtemp_flag_o); endproperty
    a_ot_off: assert property (p_ot_off) else $error("overtemp not handled");
    property p_ov_off;
        $rose(supply_overvoltage_detect_i) |->
            ##[1:10] (switch_on_o == 12'h000 && supply_overvoltage_flag_o);
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("overvoltage not handled");
    property p_flag_clear;
        ($fell(overcurrent_flag_o) || $fell(overtemp_flag_o) || $fell(supply_overvoltage_flag_o))
            |-> chip_select_n_i && since_cs_q >= 5'h03 && since_cs_q <= 5'h0c;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag cleared off frame");
    property p_hold_in_frame; !chip_select_n_i |-> $stable(switch_on_o); endproperty
    a_hold_in_frame: assert property (p_hold_in_frame) else $error("switches moved in frame");
    property p_so_edge;
        $changed(serial_data_o) && !chip_select_n_i |-> since_rise_q >= 5'h01 && since_rise_q <= 5'h06;
    endproperty
    a_so_edge: assert property (p_so_edge) else $error("serial out moved off rise");
    property p_so_idle; chip_select_n_i && since_cs_q > 5'h08 |-> !serial_data_o; endproperty
    a_so_idle: assert property (p_so_idle) else $error("serial out busy while idle");
    property p_reset;
        disable iff (1'b0) srst_i |=> switch_on_o == 12'h000 && half_bridge_hiz_o == 6'h3f &&
            !overcurrent_flag_o && !overtemp_flag_o && !supply_overvoltage_flag_o;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    c_oc: cover property ($rose(overcurrent_flag_o));
    c_ov_clear: cover property ($fell(supply_overvoltage_flag_o));
    c_shift: cover property (!chip_select_n_i && $rose(serial_clock_i));
endmodule
bind motor_bridge_serial_command_status motor_bridge_chk motor_bridge_chk_i (.clock_i, .srst_i,
    .chip_select_n_i, .serial_clock_i, .serial_data_i, .serial_data_o, .overcurrent_detect_i,
    .overtemp_detect_i, .supply_overvoltage_detect_i, .switch_on_o, .half_bridge_hiz_o,
    .overcurrent_flag_o, .overtemp_flag_o, .supply_overvoltage_flag_o);
`default_nettype wire

// >>> verif/motor_bridge_serial_command_status_tb_top.sv
`default_nettype none
module motor_bridge_serial_command_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic oc_det = 1'b0;
    logic ot_det = 1'b0;
    logic ov_det = 1'b0;
    logic cs_n, sclk, sdi, sdo, f_oc, f_ot, f_ov;
    logic [11:0] sw;
    logic [5:0] hiz;
    logic [15:0] sts;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    motor_bridge_serial_command_status motor_bridge_serial_command_status_i (.clock_i, .srst_i,
        .chip_select_n_i(cs_n), .serial_clock_i(sclk), .serial_data_i(sdi), .serial_data_o(sdo),
        .overcurrent_detect_i(oc_det), .overtemp_detect_i(ot_det),
        .supply_overvoltage_detect_i(ov_det), .switch_on_o(sw), .half_bridge_hiz_o(hiz),
        .overcurrent_flag_o(f_oc), .overtemp_flag_o(f_ot), .supply_overvoltage_flag_o(f_ov));
    spi_ctrl_model spi_ctrl_model_i (.clock_i, .status_bit_i(sdo), .chip_select_n_o(cs_n),
        .serial_clock_o(sclk), .command_bit_o(sdi));
    initial forever #5 clock_i = ~clock_i;
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    end
    task automatic cmp_status(input logic [15:0] exp);
        check_count++;
        if (sts !== exp) begin
            miscompares++;
            $display("BAD %0t status %h exp %h", $time, sts, exp);
        end
    endtask
    // flags given as {overvoltage, overtemp, overcurrent}
    task automatic cmp_out(input logic [11:0] esw, input logic [2:0] eflag);
        logic [5:0] ehiz;
        for (int h = 0; h < 6; h++) ehiz[h] = !(esw[2*h] | esw[2*h+1]);
        check_count++;
        if ({sw, hiz, f_ov, f_ot, f_oc} !== {esw, ehiz, eflag}) begin
            miscompares++;
            $display("BAD %0t outputs %h %h %b%b%b", $time, sw, hiz, f_ov, f_ot, f_oc);
        end
    endtask
    task automatic frame(input logic [15:0] w, input int n = 16, input int half = 4);
        spi_ctrl_model_i.xfer(w, n, half, sts);
    endtask
    task automatic settle();
        repeat (20) @(negedge clock_i);
    endtask
    task automatic t_basic();
        cmp_out(12'h000, 3'b000);
        frame(16'h024e);
        cmp_status(16'h0000);
        cmp_out(12'h124, 3'b000);
        frame(16'h0154);
        cmp_status(16'h0248);
        cmp_out(12'h0aa, 3'b000);
        frame(16'h0009);
        cmp_status(16'h0154);
        cmp_out(12'h004, 3'b000);
        $display("t_basic done");
    endtask
    task automatic t_framing();
        frame(16'h0ffe, 8);
        cmp_out(12'h004, 3'b000);
        frame(16'h0010, 16, 8);
        cmp_status(16'h0008);
        cmp_out(12'h008, 3'b000);
        $display("t_framing done");
    endtask
    task automatic t_overcurrent();
        oc_det = 1'b1;
        settle();
        cmp_out(12'h000, 3'b001);
        oc_det = 1'b0;
        settle();
        cmp_out(12'h000, 3'b001);
        frame(16'h0008);
        cmp_status(16'h2000);
        cmp_out(12'h000, 3'b001);
        frame(16'h2008);
        cmp_out(12'h004, 3'b000);
        $display("t_overcurrent done");
    endtask
    task automatic t_overtemp();
        ot_det = 1'b1;
        settle();
        cmp_out(12'h000, 3'b010);
        ot_det = 1'b0;
        settle();
        cmp_out(12'h004, 3'b010);
        frame(16'h4010);
        cmp_status(16'h4008);
        cmp_out(12'h008, 3'b000);
        $display("t_overtemp done");
    endtask
    task automatic t_overvoltage();
        ov_det = 1'b1;
        settle();
        cmp_out(12'h000, 3'b100);
        ov_det = 1'b0;
        settle();
        cmp_out(12'h008, 3'b100);
        frame(16'h8004);
        cmp_status(16'h8010);
        cmp_out(12'h002, 3'b000);
        $display("t_overvoltage done");
    endtask
    task automatic t_combined();
        oc_det = 1'b1;
        ot_det = 1'b1;
        settle();
        oc_det = 1'b0;
        ot_det = 1'b0;
        settle();
        frame(16'h8009);
        cmp_out(12'h000, 3'b000);
        frame(16'h0009);
        cmp_status(16'h0000);
        cmp_out(12'h004, 3'b000);
        $display("t_combined done");
    endtask
    initial begin
        repeat (4) @(negedge clock_i);
        srst_i = 1'b0;
        repeat (4) @(negedge clock_i);
        t_basic();
        t_framing();
        t_overcurrent();
        t_overtemp();
        t_overvoltage();
        t_combined();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> verif/spi_ctrl_model.sv
`default_nettype none
module spi_ctrl_model (
    input wire logic clock_i,
    input wire logic status_bit_i,
    output logic chip_select_n_o,
    output logic serial_clock_o,
    output logic command_bit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        chip_select_n_o = 1'b1;
        serial_clock_o = 1'b0;
        command_bit_o = 1'b0;
    end
    // status is taken just before the next rise, as the block's output lags the rise
    task automatic xfer(input logic [15:0] word, input int nbits, input int half,
                        output logic [15:0] status);
        status = 16'h0000;
        @(negedge clock_i);
        chip_select_n_o = 1'b0;
        repeat (half) @(negedge clock_i);
        for (int i = nbits - 1; i >= 0; i--) begin
            command_bit_o = word[i];
            serial_clock_o = 1'b1;
            repeat (half) @(negedge clock_i);
            serial_clock_o = 1'b0;
            repeat (half) @(negedge clock_i);
            status[i] = status_bit_i;
        end
        chip_select_n_o = 1'b1;
        command_bit_o = 1'b0; // pulled down once released
        repeat (12) @(negedge clock_i);
    endtask
endmodule
`default_nettype wire
